// *** sfcd_defines.svh ***
// Opcodes, status bit positions, byte counts and identity constants.
`ifndef SFCD_DEFINES_SVH
`define SFCD_DEFINES_SVH
`define SFCD_OP_WLSET     8'h06
`define SFCD_OP_WLCLR     8'h04
`define SFCD_OP_IDENT     8'h9F
`define SFCD_OP_RDSTAT    8'h05
`define SFCD_OP_WRSTAT    8'h01
`define SFCD_OP_READ      8'h03
`define SFCD_OP_FAST      8'h0B
`define SFCD_OP_PAGE      8'h02
`define SFCD_OP_SECTOR    8'hD8
`define SFCD_OP_FULL      8'hC7
`define SFCD_OP_SLEEP     8'hB9
`define SFCD_OP_WAKE      8'hAB
`define SFCD_SR_BUSY      0
`define SFCD_SR_WEL       1
`define SFCD_SR_BP_LO     2
`define SFCD_SR_BP_HI     4
`define SFCD_SR_SRWD      7
`define SFCD_BP_NONE      3'h0
`define SFCD_BIT_LAST     3'h7
`define SFCD_BIT_FIRST    3'h0
`define SFCD_CNT_ZERO     9'h000
`define SFCD_CNT_ONE      9'h001
`define SFCD_CNT_MAX      9'h1FF
`define SFCD_LEN_OPC      9'h001
`define SFCD_LEN_WRSTAT   9'h002
`define SFCD_ADDR_FIRST   9'h001
`define SFCD_ADDR_LAST    9'h003
`define SFCD_LEN_SECTOR   9'h004
`define SFCD_READ_START   9'h004
`define SFCD_FAST_START   9'h005
`define SFCD_WAKE_START   9'h004
`define SFCD_PAGE_MIN     9'h005
`define SFCD_PAGE_MAX     9'h104
`define SFCD_ID_MAKER     9'h000
`define SFCD_ID_TYPE      9'h001
`define SFCD_ID_CAP       9'h002
`define SFCD_ID_UIDLEN    9'h003
`define SFCD_ID_LAST      9'h013
`define SFCD_UID_LEN      8'h10
`define SFCD_ADDR_STEP    24'h000001
`endif

// *** sfcd_fifo.sv ***
// Flip-flop FIFO with flush, valid and ready on both sides.
`timescale 1ns/1ns
module sfcd_fifo import sfcd_pkg::*; #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 32
) (
	input  wire logic             clock_i,
	input  wire logic             rst_i,
	input  wire logic             flush_i,
	sfcd_stream_if.snk            in_s,
	output logic      [WIDTH-1:0] out_data_o,
	output logic                  out_valid_o,
	input  wire logic             out_ready_i
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_ff [DEPTH];
	logic [AW:0]      wr_ptr_ff;
	logic [AW:0]      rd_ptr_ff;
	logic             full;
	logic             empty;
	logic             push;
	logic             pop;

	// Full and empty come from pointers carrying one wrap bit.
	assign empty       = (wr_ptr_ff == rd_ptr_ff);
	assign full        = (wr_ptr_ff[AW] != rd_ptr_ff[AW]) &&
	                     (wr_ptr_ff[AW-1:0] == rd_ptr_ff[AW-1:0]);
	assign in_s.ready  = ~full;
	assign push        = in_s.valid & ~full;
	assign out_valid_o = ~empty;
	assign pop         = out_ready_i & ~empty;
	assign out_data_o  = mem_ff[rd_ptr_ff[AW-1:0]];

	// Each entry loads when the write pointer names it.
	for (genvar g = 0; g < DEPTH; g++) begin : g_entry
		always_ff @(posedge clock_i or posedge rst_i) begin
			if (rst_i) begin
				mem_ff[g] <= '0;
			end else if (push && (wr_ptr_ff[AW-1:0] == AW'(g))) begin
				mem_ff[g] <= in_s.data;
			end
		end
	end

	// Pointers advance on each handshake; flush empties the buffer.
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
		end else if (flush_i) begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
		end else begin
			if (push) begin
				wr_ptr_ff <= wr_ptr_ff + 1'b1;
			end
			if (pop) begin
				rd_ptr_ff <= rd_ptr_ff + 1'b1;
			end
		end
	end
endmodule

// *** sfcd_host_model.sv ***
// Behavioural SPI host that frames bytes towards the decoder.
`timescale 1ns/1ns
module sfcd_host_model (
	input  wire logic clock_i,
	output logic      spi_cs_n_o,
	output logic      spi_sck_o,
	output logic      spi_mosi_o,
	input  wire logic spi_miso_i
);
	logic [7:0] txq[$];
	logic [7:0] rxq[$];
	// Select high and clock low between frames; the clock never runs free.
	initial begin
		spi_cs_n_o = 1'b1;
		spi_sck_o  = 1'b0;
		spi_mosi_o = 1'b0;
	end
	// Half a serial period is four system clocks.
	task automatic half();
		repeat (4) @(posedge clock_i);
	endtask
	// One frame of nbits clocks; select may rise after any bit.
	task automatic xfer(input int nbits);
		logic [7:0] sh;
		logic [7:0] rb;
		int         i;
		rxq.delete();
		sh = 8'h00;
		rb = 8'h00;
		@(posedge clock_i) spi_cs_n_o <= 1'b0;
		for (i = 0; i < nbits; i++) begin
			if (i % 8 == 0)
				sh = (txq.size() > 0) ? txq.pop_front() : 8'h00;
			spi_mosi_o <= sh[7];
			sh = {sh[6:0], 1'b0};
			half();
			spi_sck_o <= 1'b1;
			rb = {rb[6:0], spi_miso_i};
			if (i % 8 == 7)
				rxq.push_back(rb);
			half();
			spi_sck_o <= 1'b0;
		end
		half();
		spi_cs_n_o <= 1'b1;
		spi_mosi_o <= ~spi_mosi_o;
		repeat (6) @(posedge clock_i);
	endtask
endmodule

// *** sfcd_pkg.sv ***
// Types shared by the serial flash command decoder.
package sfcd_pkg;
	typedef enum logic [3:0] {
		SFCD_ST_IDLE = 4'h1,
		SFCD_ST_OPC  = 4'h2,
		SFCD_ST_BODY = 4'h4,
		SFCD_ST_SKIP = 4'h8
	} sfcd_state_type;
	typedef enum logic [3:0] {
		SFCD_CYC_NONE   = 4'h0,
		SFCD_CYC_PAGE   = 4'h1,
		SFCD_CYC_SECTOR = 4'h2,
		SFCD_CYC_FULL   = 4'h4,
		SFCD_CYC_STATUS = 4'h8
	} sfcd_cyc_type;
endpackage

// *** sfcd_stream_if.sv ***
// Valid and ready byte stream between the decoder and its buffer.
`timescale 1ns/1ns
interface sfcd_stream_if #(
	parameter int WIDTH = 8
);
	logic [WIDTH-1:0] data;
	logic             valid;
	logic             ready;
	modport src (output data, output valid, input ready);
	modport snk (input data, input valid, output ready);
endinterface

// *** sfcd_top.sv ***
// Serial flash instruction decoder with status, latch and identity logic.
//
// Behaviour
// - Opcodes, addresses and data move most significant bit first.
// - After select, sample input on each rising clock; first byte is opcode.
// - Modifying commands execute only if deselect falls on a byte boundary.
// - During a running cycle, array accesses are ignored; cycle continues.
// - Opcode 06h sets the write latch, no further bytes.
// - Opcode 04h clears the write latch, no further bytes.
// - Latch clears at reset and when clear or modifying commands complete.
// - Opcode 9Fh returns maker, type, capacity, length, sixteen custom bytes.
// - Each output bit is driven on the falling serial clock edge.
// - Identity read during a running cycle is not decoded.
// - Deselect during identity output ends the read and returns to standby.
// - Custom factory bytes read as zero unless loaded otherwise.
// - Opcode 05h returns status anytime except in sleep, repeating while clocks continue.
// - Busy flag is one while a status, program or erase cycle runs.
// - Latch flag shows the latch; when zero, modifying commands are refused.
// - 03h reads with three address bytes; 0Bh adds one dummy byte.
// - 02h page write, three address bytes, 1 to 256 data but no more than FIFO_DEPTH (32 by default); D8h sector clear.
// - C7h full clear, B9h sleep, no trailers; 01h status write, one byte.
// - ABh wakes; after three dummy bytes the signature repeats.
// - Full clear executes only when all block protect bits are zero.
`timescale 1ns/1ns
`include "sfcd_defines.svh"
module sfcd_top import sfcd_pkg::*; #(
	parameter int         FIFO_DEPTH = 32,
	parameter logic [7:0] MAKER_ID   = 8'h5A, // Arbitrary value.
	parameter logic [7:0] TYPE_ID    = 8'h3C, // Arbitrary value.
	parameter logic [7:0] CAP_ID     = 8'h4E, // Arbitrary value.
	parameter logic [7:0] SIGNATURE  = 8'h6B, // Arbitrary value.
	parameter logic [7:0] CUSTOM_ID  = 8'h00,
	parameter logic [2:0] BP_RESET   = 3'h0
) (
	input  wire logic        clock_i,
	input  wire logic        rst_i,
	input  wire logic        spi_cs_n_i,
	input  wire logic        spi_sck_i,
	input  wire logic        spi_mosi_i,
	input  wire logic        wp_n_i,
	output logic             spi_miso_o,
	output logic             spi_miso_oe_o,
	output logic             arr_rd_o,
	output logic [23:0]      arr_addr_o,
	input  wire logic [7:0]  arr_rdata_i,
	output logic             cyc_start_o,
	output sfcd_cyc_type     cyc_kind_o,
	output logic [23:0]      cyc_addr_o,
	input  wire logic        cyc_done_i,
	output logic [7:0]       prog_data_o,
	output logic             prog_valid_o,
	input  wire logic        prog_ready_i,
	output logic [7:0]       status_o,
	output logic             asleep_o
);
	logic [2:0]     cs_sync_ff;
	logic [2:0]     sck_sync_ff;
	logic [1:0]     mosi_sync_ff;
	logic [1:0]     wp_sync_ff;
	logic           cs_rise;
	logic           cs_fall;
	logic           sck_rise;
	logic           sck_fall;
	logic           mosi_s;
	sfcd_state_type state_ff;
	logic [7:0]     sh_ff;
	logic [2:0]     bit_cnt_ff;
	logic [8:0]     byte_cnt_ff;
	logic [8:0]     nxt_byte_cnt;
	logic [7:0]     op_ff;
	logic [23:0]    addr_ff;
	logic [7:0]     dat_ff;
	logic [7:0]     tx_ff;
	logic           miso_ff;
	logic           oe_ff;
	logic           wel_ff;
	logic           busy_ff;
	logic [2:0]     bp_ff;
	logic           srwd_ff;
	logic           sleep_ff;
	logic           ovf_ff;
	logic           rd_ff;
	logic [23:0]    rd_addr_ff;
	logic           start_ff;
	sfcd_cyc_type   kind_ff;
	logic [23:0]    cyc_addr_ff;
	logic [7:0]     rx_byte;
	logic           byte_done;
	logic           in_body;
	logic           op_ok;
	logic           out_phase;
	logic [7:0]     out_byte;
	logic [23:0]    cur_addr;
	logic           rd_go;
	logic           aligned;
	logic           hw_lock;
	logic           go_wlset;
	logic           go_wlclr;
	logic           go_wrstat;
	logic           go_page;
	logic           go_sector;
	logic           go_full;
	logic           go_sleep;
	logic           push_v;
	logic           drain;
	logic           fifo_valid;
	logic           flush;
	logic [7:0]     status_w;

	sfcd_stream_if #(.WIDTH(8)) wr_s ();

	// Pins cross into the clock domain through two flip-flops; select and clock have a third stage for edge detection.
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			cs_sync_ff   <= 3'h7;
			sck_sync_ff  <= 3'h0;
			mosi_sync_ff <= 2'h0;
			wp_sync_ff   <= 2'h3;
		end else begin
			cs_sync_ff   <= {cs_sync_ff[1:0], spi_cs_n_i};
			sck_sync_ff  <= {sck_sync_ff[1:0], spi_sck_i};
			mosi_sync_ff <= {mosi_sync_ff[0], spi_mosi_i};
			wp_sync_ff   <= {wp_sync_ff[0], wp_n_i};
		end
	end

	// Edge detection looks only at the settled sync stages.
	assign cs_rise  = cs_sync_ff[1] & ~cs_sync_ff[2];
	assign cs_fall  = ~cs_sync_ff[1] & cs_sync_ff[2];
	assign sck_rise = ~cs_sync_ff[1] & sck_sync_ff[1] & ~sck_sync_ff[2];
	assign sck_fall = ~cs_sync_ff[1] & ~sck_sync_ff[1] & sck_sync_ff[2];
	assign mosi_s   = mosi_sync_ff[1];

	// Incoming byte, shifted in most significant bit first.
	assign rx_byte      = {sh_ff[6:0], mosi_s};
	assign byte_done    = sck_rise && (bit_cnt_ff == `SFCD_BIT_LAST);
	assign nxt_byte_cnt = (byte_cnt_ff == `SFCD_CNT_MAX) ? byte_cnt_ff :
	                      byte_cnt_ff + `SFCD_CNT_ONE;
	assign in_body      = (state_ff == SFCD_ST_BODY);
	assign aligned      = (bit_cnt_ff == `SFCD_BIT_FIRST);
	assign hw_lock      = srwd_ff & ~wp_sync_ff[1];
	assign status_w     = {srwd_ff, 2'h0, bp_ff, wel_ff, busy_ff};

	// Opcode acceptance: sleep admits only wake, busy admits only status.
	always_comb begin
		op_ok = 1'b0;
		if (sleep_ff) begin
			op_ok = (rx_byte == `SFCD_OP_WAKE);
		end else if (busy_ff) begin
			op_ok = (rx_byte == `SFCD_OP_RDSTAT);
		end else begin
			unique case (rx_byte)
				`SFCD_OP_WLSET, `SFCD_OP_WLCLR, `SFCD_OP_IDENT,
				`SFCD_OP_RDSTAT, `SFCD_OP_WRSTAT, `SFCD_OP_READ,
				`SFCD_OP_FAST, `SFCD_OP_PAGE, `SFCD_OP_SECTOR,
				`SFCD_OP_FULL, `SFCD_OP_SLEEP, `SFCD_OP_WAKE: begin
					op_ok = 1'b1;
				end
				default: begin
					op_ok = 1'b0;
				end
			endcase
		end
	end

	// Sequencer: idle while deselected, opcode, then body or skip.
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			state_ff <= SFCD_ST_IDLE;
		end else if (cs_sync_ff[1]) begin
			state_ff <= SFCD_ST_IDLE;
		end else begin
			unique case (state_ff)
				SFCD_ST_IDLE: begin
					state_ff <= SFCD_ST_OPC;
				end
				SFCD_ST_OPC: begin
					if (byte_done) begin
						state_ff <= op_ok ? SFCD_ST_BODY : SFCD_ST_SKIP;
					end
				end
				SFCD_ST_BODY, SFCD_ST_SKIP: begin
					state_ff <= state_ff;
				end
			endcase
		end
	end

	// Bit and byte counters restart at each select.
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			sh_ff       <= 8'h00;
			bit_cnt_ff  <= `SFCD_BIT_FIRST;
			byte_cnt_ff <= `SFCD_CNT_ZERO;
			op_ff       <= 8'h00;
			dat_ff      <= 8'h00;
		end else if (cs_fall) begin
			bit_cnt_ff  <= `SFCD_BIT_FIRST;
			byte_cnt_ff <= `SFCD_CNT_ZERO;
		end else if (sck_rise) begin
			sh_ff      <= rx_byte;
			bit_cnt_ff <= bit_cnt_ff + 3'h1;
			if (byte_done) begin
				byte_cnt_ff <= nxt_byte_cnt;
				if (state_ff == SFCD_ST_OPC) begin
					op_ff <= rx_byte;
				end
				if (byte_cnt_ff == `SFCD_CNT_ONE) begin
					dat_ff <= rx_byte;
				end
			end
		end
	end

	// Output starts once the opcode and its trailing bytes are in.
	always_comb begin
		out_phase = 1'b0;
		out_byte  = 8'h00;
		if (in_body) begin
			unique case (op_ff)
				`SFCD_OP_RDSTAT: begin
					out_phase = (byte_cnt_ff >= `SFCD_LEN_OPC);
					out_byte  = status_w;
				end
				`SFCD_OP_IDENT: begin
					out_phase = (byte_cnt_ff >= `SFCD_LEN_OPC);
					unique case (byte_cnt_ff - `SFCD_LEN_OPC)
						`SFCD_ID_MAKER:  out_byte = MAKER_ID;
						`SFCD_ID_TYPE:   out_byte = TYPE_ID;
						`SFCD_ID_CAP:    out_byte = CAP_ID;
						`SFCD_ID_UIDLEN: out_byte = `SFCD_UID_LEN;
						default:         out_byte = CUSTOM_ID;
					endcase
				end
				`SFCD_OP_READ: begin
					out_phase = (byte_cnt_ff >= `SFCD_READ_START);
					out_byte  = arr_rdata_i;
				end
				`SFCD_OP_FAST: begin
					out_phase = (byte_cnt_ff >= `SFCD_FAST_START);
					out_byte  = arr_rdata_i;
				end
				`SFCD_OP_WAKE: begin
					out_phase = (byte_cnt_ff >= `SFCD_WAKE_START);
					out_byte  = SIGNATURE;
				end
				default: begin
					out_phase = 1'b0;
				end
			endcase
		end
	end

	// Serial output changes on falling clock edges, MSB first.
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			tx_ff   <= 8'h00;
			miso_ff <= 1'b0;
			oe_ff   <= 1'b0;
		end else if (cs_sync_ff[1]) begin
			oe_ff <= 1'b0;
		end else if (sck_fall && out_phase) begin
			oe_ff <= 1'b1;
			if (aligned) begin
				miso_ff <= out_byte[7];
				tx_ff   <= {out_byte[6:0], 1'b0};
			end else begin
				miso_ff <= tx_ff[7];
				tx_ff   <= {tx_ff[6:0], 1'b0};
			end
		end
	end

	// Address collection and array read requests with auto increment.
	assign cur_addr = (byte_cnt_ff == `SFCD_ADDR_LAST) ?
	                  {addr_ff[15:0], rx_byte} : addr_ff;
	assign rd_go = byte_done && in_body &&
	               (((op_ff == `SFCD_OP_READ) &&
	                 (nxt_byte_cnt >= `SFCD_READ_START)) ||
	                ((op_ff == `SFCD_OP_FAST) &&
	                 (nxt_byte_cnt >= `SFCD_FAST_START)));
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			addr_ff    <= 24'h000000;
			rd_ff      <= 1'b0;
			rd_addr_ff <= 24'h000000;
		end else begin
			rd_ff <= rd_go;
			if (rd_go) begin
				rd_addr_ff <= cur_addr;
				addr_ff    <= cur_addr + `SFCD_ADDR_STEP;
			end else if (byte_done && in_body &&
			             (byte_cnt_ff >= `SFCD_ADDR_FIRST) &&
			             (byte_cnt_ff <= `SFCD_ADDR_LAST)) begin
				addr_ff <= {addr_ff[15:0], rx_byte};
			end
		end
	end

	// Commands that execute at deselect, each checked for length; modifying ones also for latch.
	always_comb begin
		go_wlset  = 1'b0;
		go_wlclr  = 1'b0;
		go_wrstat = 1'b0;
		go_page   = 1'b0;
		go_sector = 1'b0;
		go_full   = 1'b0;
		go_sleep  = 1'b0;
		if (cs_rise && in_body && aligned) begin
			go_wlset  = (op_ff == `SFCD_OP_WLSET) &&
			            (byte_cnt_ff == `SFCD_LEN_OPC);
			go_wlclr  = (op_ff == `SFCD_OP_WLCLR) &&
			            (byte_cnt_ff == `SFCD_LEN_OPC);
			go_wrstat = (op_ff == `SFCD_OP_WRSTAT) && wel_ff && !hw_lock &&
			            (byte_cnt_ff == `SFCD_LEN_WRSTAT);
			go_page   = (op_ff == `SFCD_OP_PAGE) && wel_ff && !ovf_ff &&
			            (byte_cnt_ff >= `SFCD_PAGE_MIN) &&
			            (byte_cnt_ff <= `SFCD_PAGE_MAX);
			go_sector = (op_ff == `SFCD_OP_SECTOR) && wel_ff &&
			            (byte_cnt_ff == `SFCD_LEN_SECTOR);
			go_full   = (op_ff == `SFCD_OP_FULL) && wel_ff &&
			            (bp_ff == `SFCD_BP_NONE) &&
			            (byte_cnt_ff == `SFCD_LEN_OPC);
			go_sleep  = (op_ff == `SFCD_OP_SLEEP) &&
			            (byte_cnt_ff == `SFCD_LEN_OPC);
		end
	end

	// Latch, busy, protection and sleep state.
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			wel_ff   <= 1'b0;
			busy_ff  <= 1'b0;
			bp_ff    <= BP_RESET;
			srwd_ff  <= 1'b0;
			sleep_ff <= 1'b0;
		end else begin
			if (go_wlset) begin
				wel_ff <= 1'b1;
			end else if (go_wlclr || (busy_ff && cyc_done_i)) begin
				wel_ff <= 1'b0;
			end
			if (go_wrstat || go_page || go_sector || go_full) begin
				busy_ff <= 1'b1;
			end else if (cyc_done_i) begin
				busy_ff <= 1'b0;
			end
			if (go_wrstat) begin
				srwd_ff <= dat_ff[`SFCD_SR_SRWD];
				bp_ff   <= dat_ff[`SFCD_SR_BP_HI:`SFCD_SR_BP_LO];
			end
			if (go_sleep) begin
				sleep_ff <= 1'b1;
			end else if (byte_done && (state_ff == SFCD_ST_OPC) &&
			             (rx_byte == `SFCD_OP_WAKE)) begin
				sleep_ff <= 1'b0;
			end
		end
	end

	// Cycle launch towards the array.
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			start_ff    <= 1'b0;
			kind_ff     <= SFCD_CYC_NONE;
			cyc_addr_ff <= 24'h000000;
		end else begin
			start_ff <= go_wrstat | go_page | go_sector | go_full;
			if (go_page) begin
				kind_ff     <= SFCD_CYC_PAGE;
				cyc_addr_ff <= addr_ff;
			end else if (go_sector) begin
				kind_ff     <= SFCD_CYC_SECTOR;
				cyc_addr_ff <= addr_ff;
			end else if (go_full) begin
				kind_ff <= SFCD_CYC_FULL;
			end else if (go_wrstat) begin
				kind_ff <= SFCD_CYC_STATUS;
			end
		end
	end

	// Page data enters the buffer; a refused byte spoils the page.
	assign push_v     = byte_done && in_body && (op_ff == `SFCD_OP_PAGE) &&
	                    (byte_cnt_ff >= `SFCD_LEN_SECTOR);
	assign wr_s.data  = rx_byte;
	assign wr_s.valid = push_v;
	assign flush      = cs_rise && in_body && (op_ff == `SFCD_OP_PAGE) &&
	                    !go_page;
	assign drain      = busy_ff && (kind_ff == SFCD_CYC_PAGE);
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			ovf_ff <= 1'b0;
		end else if (cs_fall) begin
			ovf_ff <= 1'b0;
		end else if (push_v && !wr_s.ready) begin
			ovf_ff <= 1'b1;
		end
	end

	sfcd_fifo #(
		.WIDTH (8),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clock_i     (clock_i),
		.rst_i       (rst_i),
		.flush_i     (flush),
		.in_s        (wr_s),
		.out_data_o  (prog_data_o),
		.out_valid_o (fifo_valid),
		.out_ready_i (prog_ready_i & drain)
	);

	// Outputs.
	assign prog_valid_o  = fifo_valid & drain;
	assign spi_miso_o    = miso_ff;
	assign spi_miso_oe_o = oe_ff;
	assign arr_rd_o      = rd_ff;
	assign arr_addr_o    = rd_addr_ff;
	assign cyc_start_o   = start_ff;
	assign cyc_kind_o    = kind_ff;
	assign cyc_addr_o    = cyc_addr_ff;
	assign status_o      = status_w;
	assign asleep_o      = sleep_ff;
endmodule

// *** sfcd_top_chk.sv ***
// Concurrent checks on the decoder's top-level ports.
`timescale 1ns/1ns
module sfcd_top_chk import sfcd_pkg::*; (
	input  wire logic         clock_i,
	input  wire logic         rst_i,
	input  wire logic         spi_cs_n_i,
	input  wire logic         spi_miso_oe_o,
	input  wire logic         arr_rd_o,
	input  wire logic         cyc_start_o,
	input  wire sfcd_cyc_type cyc_kind_o,
	input  wire logic         cyc_done_i,
	input  wire logic         prog_valid_o,
	input  wire logic [7:0]   status_o,
	input  wire logic         asleep_o
);
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (rst_i);
	// The output is released once the host has stayed deselected a while.
	a_oe_released: assert property (spi_cs_n_i [*5] |-> !spi_miso_oe_o)
		else $error("output enabled while deselected");
	// A cycle starts only with the latch set and no cycle running.
	a_start_guard: assert property ($rose(cyc_start_o) |->
		$past(status_o[1]) && !$past(status_o[0]))
		else $error("cycle launched without latch or while busy");
	// Busy follows a launch within one cycle.
	a_busy_rise: assert property (cyc_start_o |-> ##[0:1] status_o[0])
		else $error("busy flag missing after launch");
	// Busy holds until the array reports completion.
	a_busy_hold: assert property (status_o[0] && !cyc_done_i &&
		!$past(cyc_done_i) |=> status_o[0])
		else $error("busy dropped without completion");
	// Completion clears busy and the latch together.
	a_done_clear: assert property (status_o[0] && cyc_done_i |->
		##[1:2] (!status_o[0] && !status_o[1]))
		else $error("completion left busy or latch set");
	// The launched kind is exactly one of the four cycles.
	a_kind_onehot: assert property (cyc_start_o |->
		##[0:1] $onehot(cyc_kind_o))
		else $error("cycle kind not one-hot");
	// Page bytes flow only during a running page cycle.
	a_prog_page: assert property (prog_valid_o |-> status_o[0] &&
		cyc_kind_o == SFCD_CYC_PAGE)
		else $error("page data outside page cycle");
	// No array read is issued while a cycle runs.
	a_read_idle: assert property (arr_rd_o |-> !status_o[0])
		else $error("array read during cycle");
	// Sleep blocks launches and reads.
	a_sleep_quiet: assert property (asleep_o |->
		!cyc_start_o && !arr_rd_o)
		else $error("activity while asleep");
	// A full clear is launched only with all protect bits clear.
	a_full_guard: assert property ($fell(cyc_start_o) &&
		cyc_kind_o == SFCD_CYC_FULL |-> $past(status_o[4:2], 2) == 3'h0)
		else $error("full clear with protect bits set");
endmodule

// *** tb.sv ***
// Self-checking bench for the serial flash command decoder.
`timescale 1ns/1ns
module tb;
	localparam logic [7:0] MAKER   = 8'h5A; // Arbitrary value.
	localparam logic [7:0] MEMTYPE = 8'h3C; // Arbitrary value.
	localparam logic [7:0] CAP     = 8'h4E; // Arbitrary value.
	localparam logic [7:0] SIG     = 8'h6B; // Arbitrary value.
	logic                  clock_i;
	logic                  rst_i;
	wire logic             spi_cs_n_i, spi_sck_i, spi_mosi_i;
	logic                  spi_miso_o, spi_miso_oe_o, arr_rd_o;
	logic [23:0]           arr_addr_o, cyc_addr_o;
	logic [7:0]            arr_rdata_i, prog_data_o, status_o;
	logic                  cyc_start_o, cyc_done_i, prog_valid_o;
	logic                  prog_ready_i, asleep_o;
	sfcd_pkg::sfcd_cyc_type cyc_kind_o;
	int                    miscompares = 0;
	int                    cmp_count = 0;
	int                    starts = 0;
	int                    oes = 0;
	sfcd_host_model u_host (.clock_i, .spi_cs_n_o(spi_cs_n_i),
		.spi_sck_o(spi_sck_i), .spi_mosi_o(spi_mosi_i),
		.spi_miso_i(spi_miso_oe_o ? spi_miso_o : 1'b1)); // Pulled up.
	sfcd_top #(.MAKER_ID(MAKER), .TYPE_ID(MEMTYPE), .CAP_ID(CAP),
		.SIGNATURE(SIG)) u_sfcd_top (.clock_i, .rst_i, .spi_cs_n_i,
		.spi_sck_i, .spi_mosi_i, .wp_n_i(1'b1), .spi_miso_o,
		.spi_miso_oe_o, .arr_rd_o, .arr_addr_o, .arr_rdata_i, .cyc_start_o,
		.cyc_kind_o, .cyc_addr_o, .cyc_done_i, .prog_data_o, .prog_valid_o,
		.prog_ready_i, .status_o, .asleep_o);
	// Clock at 50 MHz.
	initial begin
		clock_i = 1'b0;
		forever #10 clock_i = ~clock_i;
	end
	// Array model and counters of launches and driven output cycles.
	always @(posedge clock_i) begin
		arr_rdata_i <= arr_addr_o[7:0] ^ 8'h3C;
		if (cyc_start_o === 1'b1)
			starts++;
		if (spi_miso_oe_o === 1'b1)
			oes++;
	end
	task automatic print_verdict();
		$display("compares %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] got, exp);
		cmp_count++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic send(input logic [7:0] q[$], input int nbits);
		u_host.txq = q;
		u_host.xfer(nbits);
	endtask
	// Pulse completion and let the flags settle.
	task automatic done_cyc();
		@(posedge clock_i) cyc_done_i <= 1'b1;
		@(posedge clock_i) cyc_done_i <= 1'b0;
		repeat (4) @(posedge clock_i);
	endtask
	// Set the latch, send a modifying command, check the launch.
	task automatic mod_op(input logic [7:0] q[$], input int go,
		input logic [3:0] kind);
		int s0;
		s0 = starts;
		send('{8'h06}, 8);
		send(q, q.size() * 8);
		chk("launch", starts - s0, go);
		if (go) begin
			chk("kind", cyc_kind_o, kind);
			chk("busy", status_o[0], 1'b1);
			done_cyc();
			chk("latch", status_o[1], 1'b0);
		end
	endtask
	task automatic t_latch();
		send('{8'h06}, 8);
		chk("wel set", status_o[1], 1'b1);
		send('{8'h04}, 8);
		chk("wel clr", status_o[1], 1'b0);
		send('{8'h06}, 9);
		chk("wel odd", status_o[1], 1'b0);
		send('{8'h06}, 8);
		send('{8'h05}, 24);
		chk("sr0", u_host.rxq[1], 8'h02);
		chk("sr1", u_host.rxq[2], 8'h02);
		send('{8'h05}, 11); // Deselect mid byte.
		send('{8'h04}, 8);
		chk("wel end", status_o[1], 1'b0);
	endtask
	task automatic t_ident();
		logic [7:0] e;
		int         k;
		send('{8'h9F}, 8 + 21 * 8);
		for (k = 1; k < 22; k++) begin
			e = k == 1 ? MAKER : k == 2 ? MEMTYPE : k == 3 ? CAP :
				k == 4 ? 8'h10 : 8'h00;
			chk("ident", u_host.rxq[k], e);
		end
	endtask
	task automatic t_read();
		int k;
		for (k = 0; k < 2; k++) begin
			send('{k ? 8'h0B : 8'h03, 8'h12, 8'h34, 8'h56}, 48 + k * 8);
			chk("rd0", u_host.rxq[4 + k], 8'h56 ^ 8'h3C);
			chk("rd1", u_host.rxq[5 + k], 8'h57 ^ 8'h3C);
		end
	endtask
	task automatic t_protect();
		int s0;
		mod_op('{8'h01, 8'h04}, 1, 4'h8);
		chk("bp", status_o[4:2], 3'h1);
		mod_op('{8'hC7}, 0, 4'h0);
		send('{8'h04}, 8);
		mod_op('{8'h01, 8'h00}, 1, 4'h8);
		mod_op('{8'hD8, 8'h00, 8'h10, 8'h00}, 1, 4'h2);
		mod_op('{8'hC7}, 1, 4'h4);
		s0 = starts;
		send('{8'hD8, 8'h00, 8'h10, 8'h00}, 32);
		chk("no latch", starts - s0, 0);
	endtask
	// Overflow refused, then a full FIFO drained against a stalling array.
	task automatic t_page();
		logic [7:0] q[$];
		int         k, n, s0, o0;
		q = '{8'h02, 8'h01, 8'h02, 8'h03};
		for (k = 0; k < 33; k++)
			q.push_back(8'h80 | 8'(k));
		mod_op(q, 0, 4'h0);
		void'(q.pop_back());
		s0 = starts;
		send('{8'h06}, 8);
		send(q, 36 * 8);
		chk("launch", starts - s0, 1);
		chk("addr", cyc_addr_o, 24'h010203);
		o0 = oes;
		send('{8'h9F}, 24);
		chk("id busy", oes - o0, 0);
		n = 0;
		for (k = 0; k < 300 && n < 32; k++) begin
			@(posedge clock_i);
			if (prog_valid_o === 1'b1 && prog_ready_i === 1'b1) begin
				chk("prog", prog_data_o, 8'h80 | 8'(n));
				n++;
			end
			prog_ready_i <= ~prog_ready_i;
		end
		chk("drained", n, 32);
		done_cyc();
		chk("page wel", status_o[1:0], 2'h0);
	endtask
	task automatic t_sleep();
		int o0;
		send('{8'hB9}, 8);
		chk("asleep", asleep_o, 1'b1);
		send('{8'h06}, 8);
		chk("wel asleep", status_o[1], 1'b0);
		send('{8'hAB}, 48);
		chk("sig", u_host.rxq[4], SIG);
		chk("sig rpt", u_host.rxq[5], SIG);
		chk("awake", asleep_o, 1'b0);
		o0 = oes;
		send('{8'hFF}, 24);
		chk("unknown", oes - o0, 0);
		send('{8'hB9}, 8);
		send('{8'hAB}, 8);
		chk("wake only", asleep_o, 1'b0);
	endtask
	// Reset, then the scenarios in turn.
	initial begin
		rst_i        <= 1'b1;
		cyc_done_i   <= 1'b0;
		prog_ready_i <= 1'b0;
		repeat (20) @(posedge clock_i);
		rst_i <= 1'b0;
		repeat (4) @(posedge clock_i);
		chk("sr reset", status_o, 8'h00);
		t_latch();
		t_ident();
		t_read();
		t_protect();
		t_page();
		t_sleep();
		print_verdict();
	end
	// Cut a hang short well beyond the expected run time.
	initial begin
		#500000;
		miscompares++;
		print_verdict();
	end
endmodule
bind sfcd_top sfcd_top_chk u_chk (.clock_i, .rst_i, .spi_cs_n_i,
	.spi_miso_oe_o, .arr_rd_o, .cyc_start_o, .cyc_kind_o, .cyc_done_i,
	.prog_valid_o, .status_o, .asleep_o);
